// ### dmic_defs.vh
// Constants for the direct-mapped instruction cache: register indices,
// byte addresses, control field positions and array geometry.
// Assumes inclusion by bare name from the cache design file.
`ifndef DMIC_DEFS_VH
`define DMIC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses (address is four times the index)
// ----------------------------------------------------------------------
`define DMIC_CTRL_IDX 5'h02
`define DMIC_WIN0_IDX 5'h04
`define DMIC_WIN1_IDX 5'h05
`define DMIC_STAT_IDX 5'h06
`define DMIC_CTRL_ADDR 8'h08
`define DMIC_WIN0_ADDR 8'h10
`define DMIC_WIN1_ADDR 8'h14
`define DMIC_STAT_ADDR 8'h18

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define DMIC_CTRL_RST 32'h00000000
`define DMIC_CEN_BIT 31
`define DMIC_LID_BIT 28
`define DMIC_WINV_BIT 24
`define DMIC_EIB_BIT 10
`define DMIC_DNC_BIT 9
`define DMIC_DIMP_BIT 8
`define DMIC_DWP_BIT 5
`define DMIC_LNF_HI 1
`define DMIC_LNF_LO 0

// ----------------------------------------------------------------------
// Access window fields and reset value
// ----------------------------------------------------------------------
`define DMIC_WIN_RST 32'h00000000
`define DMIC_WBASE_HI 31
`define DMIC_WBASE_LO 24
`define DMIC_WMASK_HI 23
`define DMIC_WMASK_LO 16
`define DMIC_WEN_BIT 15
`define DMIC_WNC_BIT 6
`define DMIC_WIMP_BIT 5
`define DMIC_WWP_BIT 2

// ----------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------
`define DMIC_LINES 256
`define DMIC_WORDS 1024
`define DMIC_INV_LAST 8'hff
`define DMIC_BEATS_LINE 3'h4
`define DMIC_BEATS_WORD 3'h1

`endif

// ### dmic_icache.v
// Direct-mapped instruction cache with line-fill buffer, access windows,
// invalidation sequencer and a plain register port.
// Assumes one 10 MHz clock, synchronous inputs, and an external memory
// port that answers each requested longword with a one-cycle ack.
//
// Function
// - Direct-mapped store of 256 lines of 16 bytes, 4 KB total.
// - 256-entry tag array with valid bit, data array 1024 x 32.
// - Tag and data read in parallel, index [11:4], word [11:2].
// - Array hit when stored tag equals address [31:12] and line valid.
// - Array hit returns the selected word in a single cycle.
// - One valid bit per line, so only whole lines enter the arrays.
// - Fill buffer holds last missed line, checked with every fetch while enable bit 31 is set.
// - Buffer valid per longword; arrived longword is served at once.
// - Miss in arrays and buffer starts an external fetch, usually a line.
// - Bus released after first longword of a miss; rest streams in.
// - Core fetches and debug instruction fetches handled identically.
// - SRAM-mapped fetch: no cache answer, no external reference.
// - Attributes from first matching window, window 0 before 1.
// - No window match: default attributes from the control register.
// - Control bit 24 walks the tag array, one entry a cycle, 256 cycles.
// - Fetches stall while whole invalidation runs.
// - Line invalidate clears entry at source [11:4] when bit 28 clear.
// - Invalidations accepted from core or debug module.
// - Reset clears control register, leaves tags and valid bits.
// - Arrays looked up and filled only while enable bit 31 is set.
// - Line fill starts at missed longword, then wraps modulo 16 bytes.
// - Next miss copies buffer only if full and still most recent.
//
// Our own choices: strobed register access and the register offsets.

`timescale 1ns/100ps
`include "dmic_defs.vh"
`default_nettype none

module dmic_icache (
  input wire clock, // Core clock
  input wire sys_rst, // Synchronous reset, active high
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  output reg [31:0] reg_rdata_ff, // Read data, cycle after strobe
  input wire req_valid, // Fetch request from core or debug
  input wire [31:0] req_addr, // Fetch address
  input wire req_ifetch, // Request is an instruction fetch
  input wire req_sram, // Address maps into on-chip SRAM
  output wire req_stall, // Hold the request this cycle
  output reg rsp_valid_ff, // Fetch answer valid
  output reg [31:0] rsp_data_ff, // Fetch answer data
  output reg [2:0] rsp_attr_ff, // Attributes {noncache, imprecise, wp}
  input wire linv_valid, // Line invalidate from core or debug
  input wire [31:0] linv_addr, // Line invalidate source address
  output wire ext_req, // External longword request
  output reg [31:0] ext_addr_ff, // External longword address
  output reg ext_line_ff, // Current external fetch is a line burst
  input wire ext_ack, // External longword returned
  input wire [31:0] ext_rdata // External longword data
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_FILL = 3'h2;
  localparam [2:0] ST_SNGL = 3'h4;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function win_match;
    input [31:0] win;
    input [31:0] addr;
    begin
      win_match = win[`DMIC_WEN_BIT] &
        (((addr[31:24] ^ win[`DMIC_WBASE_HI:`DMIC_WBASE_LO]) &
        ~win[`DMIC_WMASK_HI:`DMIC_WMASK_LO]) == 8'h00);
    end
  endfunction

  function [2:0] win_attr;
    input [31:0] win;
    begin
      win_attr = {win[`DMIC_WNC_BIT], win[`DMIC_WIMP_BIT],
        win[`DMIC_WWP_BIT]};
    end
  endfunction

  // Critical-word table: longword only for the late words of a line
  function line_sized;
    input [1:0] lnf;
    input [1:0] w;
    begin
      case (lnf)
        2'h0: line_sized = (w != 2'h3);
        2'h1: line_sized = ~w[1];
        default: line_sized = 1'b1;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [19:0] tag_mem [0:`DMIC_LINES-1];
  reg vld_mem [0:`DMIC_LINES-1];
  reg [31:0] data_mem [0:`DMIC_WORDS-1];
  reg [31:0] buf_data_ff [0:3];

  reg [31:0] cache_control_reg;
  reg [31:0] access_window_0;
  reg [31:0] access_window_1;
  reg inv_busy_ff;
  reg [7:0] inv_idx_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [27:0] buf_tag_ff;
  reg [3:0] buf_vld_ff;
  reg buf_on_ff;
  reg buf_mru_ff;
  reg buf_to_arr_ff;
  reg [1:0] beat_w_ff;
  reg [2:0] beats_left_ff;
  integer i;

  // --------------------------------------------------------------------
  // Lookup
  // --------------------------------------------------------------------
  wire cen = cache_control_reg[`DMIC_CEN_BIT];
  wire [7:0] idx = req_addr[11:4];
  wire [9:0] widx = req_addr[11:2];
  wire [1:0] wsel = req_addr[3:2];
  wire m0 = win_match(access_window_0, req_addr);
  wire m1 = win_match(access_window_1, req_addr);
  wire [2:0] dflt_attr = {cache_control_reg[`DMIC_DNC_BIT],
    cache_control_reg[`DMIC_DIMP_BIT], cache_control_reg[`DMIC_DWP_BIT]};
  // Window 0 has priority over window 1
  wire [2:0] eff_attr = m0 ? win_attr(access_window_0) :
    m1 ? win_attr(access_window_1) : dflt_attr;
  wire cacheable = ~eff_attr[2];
  // Debug instruction fetches arrive on the same port as core fetches
  wire ifetch = req_valid & req_ifetch & ~req_sram;
  wire look_ok = ifetch & ~inv_busy_ff;
  wire arr_hit = look_ok & cen & cacheable & vld_mem[idx] &
    (tag_mem[idx] == req_addr[31:12]);
  wire buf_line = cen & buf_on_ff & (buf_tag_ff == req_addr[31:4]);
  wire buf_hit = look_ok & buf_line & buf_vld_ff[wsel];
  wire sngl_done = look_ok & state_ff[2] & ext_ack;
  wire served = arr_hit | buf_hit | sngl_done;
  wire need = look_ok & ~served;
  wire idle = state_ff[0];
  wire buffered = cen & (cacheable | cache_control_reg[`DMIC_EIB_BIT]);
  // A second miss waits in the stall until the fill is over
  wire start_fill = need & idle & buffered;
  wire start_sngl = need & idle & ~buffered;
  wire start_any = start_fill | start_sngl;
  wire lsize = line_sized(cache_control_reg[`DMIC_LNF_HI:`DMIC_LNF_LO],
    wsel);
  wire buf_full = &buf_vld_ff;
  wire do_copy = start_any & buf_on_ff & buf_full & buf_mru_ff &
    buf_to_arr_ff & cen & ~inv_busy_ff;
  wire linv_go = linv_valid &
    ~cache_control_reg[`DMIC_LID_BIT];
  wire wr_ctrl = reg_wr & (reg_addr == `DMIC_CTRL_ADDR);

  // Stall covers invalidation, outstanding first word and queued misses
  assign req_stall = ifetch & ~served;
  assign ext_req = ~idle;

  // --------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      cache_control_reg <= `DMIC_CTRL_RST;
      access_window_0 <= `DMIC_WIN_RST;
      access_window_1 <= `DMIC_WIN_RST;
      reg_rdata_ff <= 32'h00000000;
    end
    else
    begin
      if (wr_ctrl)
      begin
        cache_control_reg <= reg_wdata;
        // Whole-invalidate bit is an action, not stored state
        cache_control_reg[`DMIC_WINV_BIT] <= 1'b0;
      end
      if (reg_wr & (reg_addr == `DMIC_WIN0_ADDR))
        access_window_0 <= reg_wdata;
      if (reg_wr & (reg_addr == `DMIC_WIN1_ADDR))
        access_window_1 <= reg_wdata;
      if (reg_rd)
      begin
        case (reg_addr)
          `DMIC_CTRL_ADDR:
          begin
            reg_rdata_ff <= cache_control_reg;
            reg_rdata_ff[`DMIC_WINV_BIT] <= inv_busy_ff;
          end
          `DMIC_WIN0_ADDR: reg_rdata_ff <= access_window_0;
          `DMIC_WIN1_ADDR: reg_rdata_ff <= access_window_1;
          `DMIC_STAT_ADDR: reg_rdata_ff <= {24'h000000, buf_vld_ff,
            buf_mru_ff, buf_on_ff, ~idle, inv_busy_ff};
          default: reg_rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Whole invalidation sequencer
  // --------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      inv_busy_ff <= 1'b0;
      inv_idx_ff <= 8'h00;
    end
    else if (wr_ctrl & reg_wdata[`DMIC_WINV_BIT])
    begin
      inv_busy_ff <= 1'b1;
      inv_idx_ff <= 8'h00;
    end
    else if (inv_busy_ff)
    begin
      inv_idx_ff <= inv_idx_ff + 8'h01;
      if (inv_idx_ff == `DMIC_INV_LAST)
        inv_busy_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Tag, valid and data arrays
  // --------------------------------------------------------------------
  // No reset here: tags and valid bits survive a hardware reset
  always @(posedge clock)
  begin
    if (do_copy)
    begin
      tag_mem[buf_tag_ff[7:0]] <= buf_tag_ff[27:8];
      vld_mem[buf_tag_ff[7:0]] <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
        data_mem[{buf_tag_ff[7:0], i[1:0]}] <= buf_data_ff[i];
    end
    // Invalidation is written last so it wins over a same-index copy
    if (linv_go)
      vld_mem[linv_addr[11:4]] <= 1'b0;
    if (inv_busy_ff)
      vld_mem[inv_idx_ff] <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Miss state machine
  // --------------------------------------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_fill)
          nxt_state = ST_FILL;
        else if (start_sngl)
          nxt_state = ST_SNGL;
      end
      ST_FILL:
      begin
        if (ext_ack & (beats_left_ff == 3'h1))
          nxt_state = ST_IDLE;
      end
      ST_SNGL:
      begin
        if (ext_ack)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      ext_addr_ff <= 32'h00000000;
      ext_line_ff <= 1'b0;
      beat_w_ff <= 2'h0;
      beats_left_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (start_any)
      begin
        ext_addr_ff <= {req_addr[31:2], 2'h0};
        beat_w_ff <= wsel;
        ext_line_ff <= start_fill & lsize;
        beats_left_ff <= (start_fill & lsize) ? `DMIC_BEATS_LINE :
          `DMIC_BEATS_WORD;
      end
      else if (~idle & ext_ack)
      begin
        // Next longword wraps inside the 16-byte line
        beat_w_ff <= beat_w_ff + 2'h1;
        ext_addr_ff[3:2] <= beat_w_ff + 2'h1;
        beats_left_ff <= beats_left_ff - 3'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Fill buffer
  // --------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      buf_tag_ff <= 28'h0000000;
      buf_vld_ff <= 4'h0;
      buf_on_ff <= 1'b0;
      buf_mru_ff <= 1'b0;
      buf_to_arr_ff <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        buf_data_ff[i] <= 32'h00000000;
    end
    else if (inv_busy_ff)
    begin
      // Buffered line is stale once the whole cache is flushed
      buf_on_ff <= 1'b0;
      buf_vld_ff <= 4'h0;
      buf_mru_ff <= 1'b0;
    end
    else
    begin
      if (start_fill)
      begin
        buf_tag_ff <= req_addr[31:4];
        buf_vld_ff <= 4'h0;
        buf_on_ff <= 1'b1;
        buf_mru_ff <= 1'b1;
        // Noncacheable lines live only in the buffer
        buf_to_arr_ff <= cacheable;
      end
      else if (state_ff[1] & ext_ack)
      begin
        buf_data_ff[beat_w_ff] <= ext_rdata;
        buf_vld_ff[beat_w_ff] <= 1'b1;
      end
      // Array access at the buffer's slot makes the array most recent
      if (arr_hit & ~buf_hit & (idx == buf_tag_ff[7:0]))
        buf_mru_ff <= 1'b0;
      if (linv_go & (linv_addr[11:4] == buf_tag_ff[7:0]))
        buf_mru_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Fetch answer
  // --------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 32'h00000000;
      rsp_attr_ff <= 3'h0;
    end
    else
    begin
      // SRAM fetches never reach served, so no answer is given
      rsp_valid_ff <= served;
      if (served)
      begin
        rsp_attr_ff <= eff_attr;
        if (arr_hit)
          rsp_data_ff <= data_mem[widx];
        else if (buf_hit)
          rsp_data_ff <= buf_data_ff[wsel];
        else
          rsp_data_ff <= ext_rdata;
      end
    end
  end

endmodule // dmic_icache

`default_nettype wire

// ### dmic_icache_monitor.sv
// Checker for the instruction cache, watching only its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "dmic_defs.vh"
`default_nettype none
module dmic_icache_monitor (
  input wire logic clock, // Core clock
  input wire logic sys_rst, // Sync reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic req_valid, // Fetch request
  input wire logic [31:0] req_addr, // Fetch address
  input wire logic req_ifetch, // Instruction fetch
  input wire logic req_sram, // SRAM mapped
  input wire logic req_stall, // Request held
  input wire logic rsp_valid_ff, // Answer valid
  input wire logic ext_req, // External request
  input wire logic [31:0] ext_addr_ff, // External address
  input wire logic ext_line_ff, // Line burst
  input wire logic ext_ack // External answer
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic [8:0] inv_cnt_ff;
  logic [1:0] beats_ff;
  logic en_ff;
  wire fetch = req_valid && req_ifetch && !req_sram;
  wire ctrl_wr = reg_wr && reg_addr == `DMIC_CTRL_ADDR;
  // --------
  // Shadow state
  // --------
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      inv_cnt_ff <= 9'h000;
      beats_ff <= 2'h0;
      en_ff <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        en_ff <= reg_wdata[`DMIC_CEN_BIT];
      if (ctrl_wr && reg_wdata[`DMIC_WINV_BIT])
        inv_cnt_ff <= 9'h100;
      else if (inv_cnt_ff != 9'h000)
        inv_cnt_ff <= inv_cnt_ff - 9'h001;
      if (ext_ack && ext_req && ext_line_ff)
        beats_ff <= beats_ff + 2'h1;
    end
  end
  sequence s_taken;
    fetch && !req_stall;
  endsequence
  sequence s_beat;
    ext_req && ext_ack && ext_line_ff && beats_ff != 2'h3;
  endsequence
  a_taken_answer: assert property (s_taken |=> rsp_valid_ff)
    else $error("taken fetch got no answer");
  a_answer_cause: assert property (
    rsp_valid_ff |-> $past(fetch && !req_stall))
    else $error("answer without taken fetch");
  a_sram_free: assert property (
    req_valid && req_sram |-> !req_stall ##1 !rsp_valid_ff)
    else $error("cache acted on sram fetch");
  a_nonfetch_quiet: assert property (
    req_valid && !req_ifetch |=> !rsp_valid_ff)
    else $error("answer to non fetch");
  a_inv_stall: assert property (
    fetch && inv_cnt_ff != 9'h000 |-> req_stall)
    else $error("fetch taken during invalidation");
  a_ext_hold: assert property (
    ext_req && !ext_ack |=> ext_req && $stable(ext_addr_ff))
    else $error("external request dropped early");
  a_beat_wrap: assert property (s_beat ##1 ext_req |->
    ext_addr_ff[31:4] == $past(ext_addr_ff[31:4]) &&
    ext_addr_ff[3:2] == $past(ext_addr_ff[3:2]) + 2'h1)
    else $error("burst beat order wrong");
  a_line_crit: assert property (
    $rose(ext_req) && ext_line_ff && beats_ff == 2'h0
    |-> ext_addr_ff == {$past(req_addr[31:2]), 2'h0})
    else $error("burst not critical first");
  a_disabled_single: assert property (
    $rose(ext_req) && !en_ff |-> !ext_line_ff)
    else $error("line burst while disabled");
endmodule // dmic_icache_monitor
bind dmic_icache dmic_icache_monitor i_mon (.clock, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .req_valid, .req_addr, .req_ifetch, .req_sram,
  .req_stall, .rsp_valid_ff, .ext_req, .ext_addr_ff, .ext_line_ff, .ext_ack);
`default_nettype wire

// ### dmic_mem_model.sv
// External memory model answering one longword request at a time.
// Assumes requests hold until acknowledged.
`timescale 1ns/100ps
`default_nettype none
module dmic_mem_model (
  input wire logic clock, // Core clock
  input wire logic slow, // One wait cycle per answer
  input wire logic ext_req, // Longword wanted
  input wire logic [31:0] ext_addr_ff, // Longword address
  output var logic ext_ack, // Longword returned
  output var logic [31:0] ext_rdata // Returned data
);
  logic wait_ff = 1'b0;
  always @(posedge clock)
  begin
    wait_ff <= ext_req && !ext_ack && !wait_ff;
    if (ext_req && !ext_ack && (!slow || wait_ff))
    begin
      ext_ack <= 1'b1;
      ext_rdata <= ~ext_addr_ff;
    end
    else
    begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata; // Never leave stale data standing
    end
  end
endmodule // dmic_mem_model
`default_nettype wire

// ### test_dmic_icache.sv
// Self-checking bench for the instruction cache.
// Assumes the memory model and checker compiled before it.
`timescale 1ns/100ps
`include "dmic_defs.vh"
`default_nettype none
module test_dmic_icache;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, req_addr = 32'h0, linv_addr = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, req_ifetch = 1'b0;
  logic req_sram = 1'b0, linv_valid = 1'b0, slow = 1'b0, rd_pend = 1'b0;
  logic [31:0] reg_rdata_ff, rsp_data_ff, ext_addr_ff, ext_rdata;
  logic [2:0] rsp_attr_ff;
  logic req_stall, rsp_valid_ff, ext_req, ext_line_ff, ext_ack;
  logic [34:0] rsp_q[$], reg_q[$];
  logic [31:0] rnd = 32'hdb06;
  int errors = 0, num_checks = 0, n;
  always #50 clock = ~clock;
  dmic_icache i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_ff, .req_valid, .req_addr, .req_ifetch, .req_sram,
    .req_stall, .rsp_valid_ff, .rsp_data_ff, .rsp_attr_ff, .linv_valid,
    .linv_addr, .ext_req, .ext_addr_ff, .ext_line_ff, .ext_ack, .ext_rdata);
  dmic_mem_model i_mem (.clock, .slow, .ext_req, .ext_addr_ff, .ext_ack,
    .ext_rdata);
  // --------
  // Checking
  // --------
  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [34:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic pop(ref logic [34:0] q[$], input string w, logic [34:0] g);
    if (q.size() == 0)
    begin
      num_checks++;
      errors++;
      $display("unexpected %s: expected none, seen %h", w, g);
    end
    else
      check(w, q.pop_front(), g);
  endtask
  always @(negedge clock)
  begin
    if (rsp_valid_ff === 1'b1)
      pop(rsp_q, "fetch answer", {rsp_attr_ff, rsp_data_ff});
    if (rd_pend)
      pop(reg_q, "register", {3'h0, reg_rdata_ff});
    rd_pend = reg_rd;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // --------
  // Drivers
  // --------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_q.push_back({3'h0, e});
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic fetch(input logic [31:0] a, input logic [2:0] at);
    req_valid <= 1'b1;
    req_ifetch <= 1'b1;
    req_addr <= a;
    n = 0;
    @(negedge clock);
    while (req_stall !== 1'b0 && n < 400)
    begin
      n++;
      @(negedge clock);
    end
    if (n == 400)
    begin
      errors++;
      report_and_stop();
    end
    rsp_q.push_back({at, ~a[31:2], 2'b11});
    @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic settle;
    int q;
    q = 0;
    for (int i = 0; i < 100 && q < 3; i++)
    begin
      @(negedge clock);
      q = ext_req ? 0 : q + 1;
    end
    if (q < 3)
    begin
      errors++;
      report_and_stop();
    end
    @(posedge clock);
  endtask
  task automatic linv(input logic [31:0] a);
    linv_valid <= 1'b1;
    linv_addr <= a;
    @(posedge clock);
    linv_valid <= 1'b0;
    @(posedge clock);
  endtask
  // --------
  // Scenarios
  // --------
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(`DMIC_CTRL_ADDR, 32'h0);
    rd(8'h3c, 32'h0);
    wr(`DMIC_CTRL_ADDR, 32'h01000000);
    fetch(32'h00002000, 3'h0);
    check("invalidate wait", 35'h1, n >= 250 && n <= 270);
    wr(`DMIC_CTRL_ADDR, 32'h80000102);
    rd(`DMIC_CTRL_ADDR, 32'h80000102);
    slow <= 1'b1;
    fetch(32'h00005008, 3'h2);
    fetch(32'h0000500c, 3'h2);
    settle();
    fetch(32'h00005000, 3'h2);
    check("buffer hit wait", 35'h0, n);
    fetch(32'h00006014, 3'h2);
    fetch(32'h00005004, 3'h2);
    check("array hit wait", 35'h0, n);
    fetch(32'h00007000, 3'h2);
    settle();
    linv(32'h00005000);
    fetch(32'h00005000, 3'h2);
    check("line cleared", 35'h1, n > 0);
    settle();
    wr(`DMIC_CTRL_ADDR, 32'h90000102);
    linv(32'h00006010);
    fetch(32'h00006018, 3'h2);
    check("line kept", 35'h0, n);
    wr(`DMIC_WIN0_ADDR, 32'h40008004);
    wr(`DMIC_WIN1_ADDR, 32'h00ff8040);
    rd(`DMIC_WIN0_ADDR, 32'h40008004);
    fetch(32'h40000104, 3'h1);
    settle();
    rd(`DMIC_STAT_ADDR, 32'h000000fc);
    fetch(32'h00009000, 3'h4);
    req_sram <= 1'b1;
    req_valid <= 1'b1;
    @(negedge clock);
    check("sram stall", 35'h0, req_stall);
    @(posedge clock);
    req_sram <= 1'b0;
    req_ifetch <= 1'b0;
    @(posedge clock);
    req_valid <= 1'b0;
    req_ifetch <= 1'b1;
    @(posedge clock);
    // Buffered noncacheable line serves its next word at once
    wr(`DMIC_CTRL_ADDR, 32'h90000502);
    slow <= 1'b0;
    fetch(32'h00009008, 3'h4);
    fetch(32'h0000900c, 3'h4);
    check("noncache buffer wait", 35'h0, n);
    settle();
    // Tags survive reset, so re-enabling without a flush must still hit
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(`DMIC_CTRL_ADDR, 32'h0);
    rd(`DMIC_STAT_ADDR, 32'h0);
    wr(`DMIC_CTRL_ADDR, 32'h80000100);
    fetch(32'h00006018, 3'h2);
    check("tags kept", 35'h0, n);
    fetch(32'h00008f0c, 3'h2);
    fetch(32'h00008f00, 3'h2);
    check("longword fill", 35'h1, n > 0);
    wr(`DMIC_WIN0_ADDR, 32'h0);
    wr(`DMIC_WIN1_ADDR, 32'h0);
    repeat (40)
    begin
      rnd = xs(rnd);
      slow <= rnd[16];
      fetch({18'h00001, rnd[13:2], 2'b00}, 3'h2);
    end
    settle();
    check("answers left", 35'h0, rsp_q.size() + reg_q.size());
    report_and_stop();
  end
endmodule // test_dmic_icache
`default_nettype wire
